//--- pofr_pkg.sv
package pofr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the axi4-lite slave)
  // ----------------------------------------------------------------
  // the auxiliary register keeps its short-bus index; its byte address is four times that
  localparam logic [7:0] aux_ctrl_one_index = 8'ha2;
  localparam logic [9:0] aux_ctrl_one_addr = {aux_ctrl_one_index, 2'b00};
  localparam logic [9:0] ctrl_addr = 10'h000;
  localparam logic [9:0] irq_status_addr = 10'h004;
  localparam logic [9:0] irq_enable_addr = 10'h008;
  localparam logic [9:0] irq_clear_addr = 10'h00c;
  localparam logic [9:0] pc_limit_addr = 10'h010;
  localparam logic [9:0] status_addr = 10'h014;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int overrun_flag_bit = 5;
  localparam int aux_const_one_bit = 4;
  localparam logic [7:0] aux_writable_mask = 8'hed;
  localparam logic [7:0] aux_reset = 8'h10;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [1:0] irq_enable_reset = 2'h0;
  localparam int irq_overrun_bit = 0;
  localparam int irq_suppressed_bit = 1;
  localparam logic [1:0] axi_resp_okay = 2'h0;
  localparam logic [1:0] axi_resp_slverr = 2'h2;

  // ----------------------------------------------------------------
  // timing: fault reset pulse length in cycles
  // ----------------------------------------------------------------
  localparam int fault_reset_cycles = 4;

  // fault sequencer states
  typedef enum logic [1:0] {
    pofr_idle = 2'b00,
    pofr_reset = 2'b01,
    pofr_hold = 2'b10
  } pofr_state_e;

  // write request carried together
  typedef struct packed {
    logic [9:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } pofr_wreq_s;

endpackage

//--- pofr_program_overrun_fault_reset.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
module pofr_program_overrun_fault_reset #(
  parameter int pc_width = 16,
  parameter logic [15:0] flash_size = 16'h4800
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // reset sources from the rest of the chip
  input wire logic power_on_reset,
  input wire logic other_reset,
  // cpu and debug side
  input wire logic [pc_width-1:0] program_counter,
  input wire logic pc_valid,
  input wire logic onchip_debug_mode,
  input wire logic debug_enable_option,
  // fault reset output
  output logic fault_reset,
  output logic program_overrun_flag,
  output logic irq,
  // axi4-lite write address
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // register map and timing
  // ----------------------------------------------------------------
  // every register is one aligned 32-bit word; unused upper bits read 0
  //   0x000 ctrl: bit 0 masks the fault reset (flag and event stay quiet unless a debug-suppressed fault sets them)
  //   0x004 irq status, read only: bit 0 fault reset, bit 1 suppressed fault
  //   0x008 irq enable, same layout as the status word
  //   0x00c irq clear, write one to clear the matching status bit
  //   0x010 pc limit, read only: the flash size this block compares against
  //   0x014 status, read only: fault reset output and sequencer state
  //   0x288 auxiliary control, low byte: the shared flag register
  // auxiliary byte layout:
  //   bit 7, 6, 3, 2, 0: plain storage owned by other blocks of the chip
  //   bit 5: overrun flag, set by hardware, cleared by writing 0
  //   bit 4: reads 1, bit 1: reads 0; writes to both are dropped
  // unmapped addresses answer slverr; their writes change nothing
  //
  // write timing: address and data are each taken on their own valid/ready
  // edge; the edge after both are held updates the register and raises
  // bvalid; bvalid stands until bready is seen high, and only then do the
  // two readies come back, so at most one write is ever in flight
  //
  // read timing: arready is high while no read data waits; the edge that
  // takes the address loads rdata and raises rvalid, which stands until
  // rready is seen high; the read path samples state one cycle early, so a
  // write landing in the same cycle is not yet visible
  //
  // fault timing: an excursion seen at edge n drives fault_reset high from
  // n+1 for fault_reset_cycles cycles, with the flag and status bit set at
  // n+1 too; the sequencer then waits for the pc to come back below the
  // flash end (or to lose validity) before it rearms, so a cpu that keeps
  // running past the end produces exactly one event per excursion
  //
  // resets: aresetn clears everything; power_on_reset clears everything but
  // the bus handshake; other_reset clears only the irq status, never the flag
  //
  // limitation: the pc is taken as synchronous and valid when pc_valid is
  // high; a glitching pc on a clock edge would be seen as a real excursion

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // address decode, shared by read and write paths
  function automatic logic addr_known(input logic [9:0] a);
    addr_known = (a == pofr_pkg::aux_ctrl_one_addr) || (a == pofr_pkg::ctrl_addr) ||
                 (a == pofr_pkg::irq_status_addr) || (a == pofr_pkg::irq_enable_addr) ||
                 (a == pofr_pkg::irq_clear_addr) || (a == pofr_pkg::pc_limit_addr) ||
                 (a == pofr_pkg::status_addr);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pofr_pkg::pofr_state_e state;
  logic [7:0] aux_reg;
  logic [7:0] ctrl;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic [2:0] rst_cnt;
  logic aw_held;
  logic w_held;
  pofr_pkg::pofr_wreq_s wreq;
  logic overrun;
  logic fault_take;
  logic fault_fire;
  logic fault_suppress;
  logic wr_go;
  logic aux_wr;
  logic [7:0] aux_wdata;

  // pc past the last flash byte; ignored while the cpu is held in reset
  // overrun detect
  assign overrun = pc_valid && !fault_reset &&
                   ({{(32-pc_width){1'b0}}, program_counter} >= {16'h0000, flash_size});
  assign fault_take = overrun && (state == pofr_pkg::pofr_idle);
  assign fault_suppress = fault_take && onchip_debug_mode && !debug_enable_option;
  assign fault_fire = fault_take && !fault_suppress && !ctrl[0];

  // ----------------------------------------------------------------
  // fault reset sequencer
  // ----------------------------------------------------------------
  // pulse a fixed-length reset, then wait for the pc to leave the fault range
  always_ff @(posedge aclk) begin
    if (!aresetn || power_on_reset) begin
      state <= pofr_pkg::pofr_idle;
      rst_cnt <= 3'h0;
    end else begin
      unique case (state)
        pofr_pkg::pofr_idle: begin
          if (fault_fire) begin
            state <= pofr_pkg::pofr_reset;
            rst_cnt <= 3'(pofr_pkg::fault_reset_cycles - 1);
          end else if (fault_suppress) begin
            state <= pofr_pkg::pofr_hold;
          end
        end
        pofr_pkg::pofr_reset: begin
          if (rst_cnt == 3'h0) begin
            state <= pofr_pkg::pofr_hold;
          end else begin
            rst_cnt <= rst_cnt - 3'h1;
          end
        end
        pofr_pkg::pofr_hold: begin
          // one event per excursion past the flash end
          if (!overrun || !pc_valid) begin
            state <= pofr_pkg::pofr_idle;
          end
        end
        default: begin
          state <= pofr_pkg::pofr_idle;
        end
      endcase
    end
  end

  assign fault_reset = (state == pofr_pkg::pofr_reset);

  // ----------------------------------------------------------------
  // auxiliary control register
  // ----------------------------------------------------------------
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign aux_wr = wr_go && (wreq.addr == pofr_pkg::aux_ctrl_one_addr) && wreq.strb[0];
  assign aux_wdata = wreq.data[7:0];

  // other_reset keeps the flag; aresetn and power-on clear it; set beats software clear
  always_ff @(posedge aclk) begin
    if (!aresetn || power_on_reset) begin
      aux_reg <= pofr_pkg::aux_reset;
    end else begin
      if (aux_wr) begin
        aux_reg <= (aux_wdata & pofr_pkg::aux_writable_mask) |
                   (aux_reg & ~pofr_pkg::aux_writable_mask) | pofr_pkg::aux_reset;
      end
      // only this fault, a software write, aresetn or power-on moves the flag
      if (fault_fire || fault_suppress) begin
        aux_reg[pofr_pkg::overrun_flag_bit] <= 1'b1;
      end
    end
  end

  // other_reset deliberately does not touch aux_reg
  assign program_overrun_flag = aux_reg[pofr_pkg::overrun_flag_bit];

  // ----------------------------------------------------------------
  // control and interrupts
  // ----------------------------------------------------------------
  // ctrl bit 0 masks the fault reset globally (flag and irq stay quiet too, except for a debug-suppressed fault)
  always_ff @(posedge aclk) begin
    if (!aresetn || power_on_reset) begin
      ctrl <= pofr_pkg::ctrl_reset;
      irq_enable <= pofr_pkg::irq_enable_reset;
    end else if (wr_go && wreq.strb[0]) begin
      if (wreq.addr == pofr_pkg::ctrl_addr) begin
        ctrl <= wreq.data[7:0];
      end
      if (wreq.addr == pofr_pkg::irq_enable_addr) begin
        irq_enable <= wreq.data[1:0];
      end
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || power_on_reset || other_reset) begin
      irq_status <= 2'h0;
    end else begin
      logic [1:0] clr;
      logic [1:0] set;
      clr = (wr_go && wreq.strb[0] && wreq.addr == pofr_pkg::irq_clear_addr) ?
            wreq.data[1:0] : 2'h0;
      set = {fault_suppress, fault_fire};
      irq_status <= (irq_status & ~clr) | set;
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  // address and data may come in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wreq <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pofr_pkg::axi_resp_okay;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        wreq.addr <= {s_axi_awaddr[9:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        wreq.data <= s_axi_wdata;
        wreq.strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(wreq.addr) ? pofr_pkg::axi_resp_okay :
                       pofr_pkg::axi_resp_slverr;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // read data registered on the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pofr_pkg::axi_resp_okay;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_known({s_axi_araddr[9:2], 2'b00}) ? pofr_pkg::axi_resp_okay :
                     pofr_pkg::axi_resp_slverr;
      unique case ({s_axi_araddr[9:2], 2'b00})
        pofr_pkg::aux_ctrl_one_addr: s_axi_rdata <= {24'h000000, aux_reg};
        pofr_pkg::ctrl_addr: s_axi_rdata <= {24'h000000, ctrl};
        pofr_pkg::irq_status_addr: s_axi_rdata <= {30'h0, irq_status};
        pofr_pkg::irq_enable_addr: s_axi_rdata <= {30'h0, irq_enable};
        pofr_pkg::pc_limit_addr: s_axi_rdata <= {16'h0000, flash_size};
        pofr_pkg::status_addr: s_axi_rdata <= {29'h0, fault_reset, state};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- pofr_chk.sv
`timescale 1ns/1ns
// ----
// fault reset checker
// ----
module pofr_chk #(
  parameter int pc_width = 16,
  parameter logic [15:0] flash_size = 16'h4800
) (
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_on_reset,
  input wire logic other_reset,
  // cpu side
  input wire logic [pc_width-1:0] program_counter,
  input wire logic pc_valid,
  input wire logic onchip_debug_mode,
  input wire logic debug_enable_option,
  // outputs watched
  input wire logic fault_reset,
  input wire logic program_overrun_flag,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || power_on_reset);
  // pc beyond the end of flash
  wire logic over = pc_valid && program_counter >= pc_width'(flash_size);
  pulse_cause_a: assert property ($rose(fault_reset) |-> $past(over))
    else $error("fault reset without overrun");
  pulse_len_a: assert property ($rose(fault_reset) |-> fault_reset[*4] ##1 !fault_reset)
    else $error("fault reset pulse length wrong");
  flag_set_a: assert property ($rose(fault_reset) |-> program_overrun_flag)
    else $error("flag not set with fault reset");
  flag_keep_a: assert property (other_reset && program_overrun_flag && s_axi_awready &&
    s_axi_wready |=> program_overrun_flag) else $error("flag lost on other reset");
  debug_hold_a: assert property ($past(onchip_debug_mode && !debug_enable_option)
    |-> !$rose(fault_reset)) else $error("fault reset in debug mode");
  por_clear_a: assert property (disable iff (!aresetn) power_on_reset |=>
    !program_overrun_flag && !fault_reset) else $error("power-on did not clear");
endmodule

//--- pofr_cpu_model.sv
`timescale 1ns/1ns
// ----
// cpu program counter model
// ----
module pofr_cpu_model (
  // clock and commands
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic jump,
  input wire logic [15:0] jump_addr,
  // towards the block
  input wire logic fault_reset,
  output logic [15:0] pc,
  output logic pc_valid
);
  // a held cpu restarts at zero; a jump stands for a runaway branch
  always_ff @(posedge aclk) begin
    if (!aresetn || fault_reset) begin
      pc <= 16'h0000;
      pc_valid <= 1'b0;
    end else begin
      pc_valid <= 1'b1;
      pc <= jump ? jump_addr : pc;
    end
  end
endmodule

//--- pofr_program_overrun_fault_reset_bench.sv
`timescale 1ns/1ns
`define CHK(n, e, a) chk(n, 34'(e), 34'(a))
module pofr_program_overrun_fault_reset_bench;
  localparam logic [15:0] flash = 16'h4800;
  localparam logic [9:0] aux = pofr_pkg::aux_ctrl_one_addr;
  logic aclk, aresetn, power_on_reset, other_reset, pc_valid, onchip_debug_mode, jump;
  logic debug_enable_option, fault_reset, program_overrun_flag, irq;
  logic [15:0] program_counter, jump_addr;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] exp_q[$], msk_q[$];
  int mismatches, check_count, pulses, width, p;
  pofr_program_overrun_fault_reset #(.flash_size(flash)) pofr_program_overrun_fault_reset_i (.*);
  pofr_cpu_model pofr_cpu_model_i (.aclk, .aresetn, .jump, .jump_addr, .fault_reset,
    .pc(program_counter), .pc_valid);
  task automatic chk(string n, logic [33:0] e, logic [33:0] a);
    check_count++;
    if (a !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, a);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic to(int n);
    if (n >= 40) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic wr(logic [9:0] a, logic [31:0] d, logic [3:0] s);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        `CHK("write response", pofr_pkg::axi_resp_okay, s_axi_bresp);
        break;
      end
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    to(n);
  endtask
  task automatic rd(logic [9:0] a, logic [33:0] e, logic [31:0] m);
    int n;
    exp_q.push_back(e);
    msk_q.push_back({2'b11, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    to(n);
  endtask
  // one branch of the cpu, then time for a whole fault pulse to finish
  task automatic go(logic [15:0] a);
    jump_addr <= a;
    jump <= 1'b1;
    @(posedge aclk);
    jump <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  // ----
  // watcher: read answers in order, length of every fault pulse
  // ----
  always @(posedge aclk) begin
    logic [33:0] m;
    if (s_axi_rvalid && s_axi_rready) begin
      m = msk_q.pop_front();
      `CHK("read", exp_q.pop_front() & m, {s_axi_rresp, s_axi_rdata} & m);
    end
    if (fault_reset === 1'b1) width++;
    else if (width != 0) begin
      `CHK("pulse width", pofr_pkg::fault_reset_cycles, width);
      pulses++;
      width = 0;
    end
  end
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // main sequence; reset held for two cycles
  initial begin
    {aresetn, power_on_reset, other_reset, onchip_debug_mode, debug_enable_option} = '0;
    {jump, jump_addr, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    void'($urandom(32'hc5a505e0));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(aux, 34'h10, 32'hff);
    rd(10'h040, {pofr_pkg::axi_resp_slverr, 32'h0}, 32'hffff_ffff);
    rd(pofr_pkg::pc_limit_addr, 34'(flash), 32'hffff);
    $display("reset test done");
    wr(pofr_pkg::irq_enable_addr, 32'h1, 4'h1);
    go(flash - 16'h1);
    `CHK("no pulse below flash end", 0, pulses);
    go(flash);
    `CHK("pulse at flash end", 1, pulses);
    `CHK("irq raised", 1, irq);
    rd(aux, 34'h30, 32'hff);
    wr(pofr_pkg::irq_clear_addr, 32'h1, 4'h1);
    `CHK("irq cleared", 0, irq);
    other_reset <= 1'b1;
    @(posedge aclk);
    other_reset <= 1'b0;
    @(posedge aclk);
    rd(aux, 34'h30, 32'hff);
    wr(aux, 32'h0, 4'h1);
    rd(aux, 34'h10, 32'hff);
    $display("overrun test done");
    for (int d = 0; d < 2; d++) begin
      onchip_debug_mode <= 1'b1;
      debug_enable_option <= d[0];
      wr(aux, 32'h0, 4'h1);
      p = pulses;
      go(flash + 16'($urandom_range(100)));
      `CHK("debug pulses", p + d, pulses);
      `CHK("masked irq", d, irq);
      rd(aux, 34'h30, 32'hff);
      rd(pofr_pkg::irq_status_addr, 34'(32'h2 >> d), 32'h2 >> d);
      go(16'h0000);
    end
    onchip_debug_mode <= 1'b0;
    $display("debug test done");
    // global mask in ctrl bit 0: no pulse and no flag for an excursion
    wr(aux, 32'h0, 4'h1);
    wr(pofr_pkg::ctrl_addr, 32'h1, 4'h1);
    p = pulses;
    go(flash);
    `CHK("masked pulses", p, pulses);
    rd(aux, 34'h10, 32'hff);
    go(16'h0000);
    wr(pofr_pkg::ctrl_addr, 32'h0, 4'h1);
    $display("mask test done");
    power_on_reset <= 1'b1;
    @(posedge aclk);
    power_on_reset <= 1'b0;
    @(posedge aclk);
    `CHK("flag after power-on", 0, program_overrun_flag);
    rd(aux, 34'h10, 32'hff);
    $display("power-on test done");
    final_report();
  end
endmodule
bind pofr_program_overrun_fault_reset pofr_chk #(.pc_width(pc_width),
  .flash_size(flash_size)) pofr_chk_i (.*);
